/* design/lisr_pkg.sv */
// Constants, types and helpers for the limit interrupt status block.
`default_nettype none

package lisr_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  // Register indices; the byte address is four times the index.
  localparam logic [5:0] IDX_FLAGS_A = 6'h00;
  localparam logic [5:0] IDX_FLAGS_B = 6'h01;
  localparam logic [5:0] IDX_MASK_A  = 6'h02;
  localparam logic [5:0] IDX_MASK_B  = 6'h03;
  localparam logic [5:0] IDX_CTRL    = 6'h04;

  localparam logic [7:0] FLAGS_RESET  = 8'h00;
  localparam logic [7:0] MASK_A_RESET = 8'hFF;
  localparam logic [7:0] MASK_B_RESET = 8'h10;
  localparam logic [7:0] CTRL_RESET   = 8'h01;
  // Only bit 4 of the second flag register is implemented.
  localparam logic [7:0] FLAGS_B_USED = 8'h10;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_INT_HIGH   = 0;
  localparam int BIT_INT_LOW    = 1;
  localparam int BIT_EXT_HIGH   = 2;
  localparam int BIT_EXT_LOW    = 3;
  localparam int BIT_FAULT      = 4;
  localparam int BIT_AIN_TWO    = 5;
  localparam int BIT_AIN_THREE  = 6;
  localparam int BIT_AIN_FOUR   = 7;
  localparam int BIT_SUPPLY     = 4;
  localparam int CTRL_EXT_MODE  = 0;
  localparam int CTRL_SOFT_RST  = 1;

  // Power-up values of the external limits, in quarter degrees.
  localparam logic [9:0] EXT_HIGH_DEFAULT = 10'h3FC;
  localparam logic [9:0] EXT_LOW_DEFAULT  = 10'h000;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CH_INT_TEMP    = 3'b000,
    CH_EXT_OR_ANALOG_INPUT_ONE = 3'b001,
    CH_AIN_TWO     = 3'b010,
    CH_AIN_THREE   = 3'b011,
    CH_AIN_FOUR    = 3'b100,
    CH_SUPPLY      = 3'b101
  } lisr_chan_t;

  typedef struct packed {
    logic       valid;
    lisr_chan_t chan;
    logic [9:0] value;
  } lisr_result_t;

  typedef struct packed {
    logic [9:0] high;
    logic [9:0] low;
  } lisr_window_t;

  typedef struct packed {
    lisr_window_t int_temp;
    lisr_window_t ext_temp;
    lisr_window_t analog_input_one;
    lisr_window_t analog_input_two;
    lisr_window_t analog_input_three;
    lisr_window_t analog_input_four;
    lisr_window_t supply_voltage;
  } lisr_limits_t;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Temperatures are twos complement, voltages are unsigned.
  function automatic logic lisr_temp_high(input logic [9:0] v,
                                          input logic [9:0] lim);
    return $signed(v) > $signed(lim);
  endfunction

  function automatic logic lisr_temp_low(input logic [9:0] v,
                                         input logic [9:0] lim);
    return $signed(v) <= $signed(lim);
  endfunction

  function automatic logic lisr_volt_out(input logic [9:0]   v,
                                         input lisr_window_t w);
    return (v > w.high) || (v <= w.low);
  endfunction

endpackage

`default_nettype wire

/* design/lisr_top.sv */
// Limit interrupt status registers with APB access and interrupt output.
//
// Contract
// - A read clears only read flag bits whose condition has gone away.
// - A software reset clears both flag registers whatever is measured.
// - Flag A bit 0 sets when internal temperature is above its high limit.
// - Flag A bit 1 sets when internal temperature is at or under low limit.
// - External mode: flag A bit 2 sets above the external high limit.
// - Analog mode: flag A bit 2 sets when analog input one is out of window.
// - External mode: flag A bit 3 sets at or under the external low limit.
// - External mode: flag A bit 4 sets on an open or short fault of the external sensor.
// - Flag A bit 5 sets when analog input two is out of its window.
// - Flag A bit 6 sets when analog input three is out of its window.
// - Flag A bit 7 sets when analog input four is out of its window.
// - Flag B bit 4 sets on supply voltage out of window; others unused.
// - At reset every flag bit is zero.
// - Any set flag bit can drive the interrupt output active.
//
// Implementation choice: register access over APB.
`default_nettype none

module lisr_top (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output var  logic [31:0]           prdata,
  output var  logic                  pready,
  output var  logic                  pslverr,
  input  wire lisr_pkg::lisr_result_t result,
  input  wire lisr_pkg::lisr_limits_t limits,
  input  wire logic                  sensor_fault,
  output var  logic                  irq
);
  import lisr_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0]  flags_a_reg;
  logic [7:0]  flags_a_next;
  logic [7:0]  flags_b_reg;
  logic [7:0]  flags_b_next;
  logic [7:0]  cond_a_reg;
  logic [7:0]  cond_a_next;
  logic [7:0]  cond_b_reg;
  logic [7:0]  cond_b_next;
  logic [7:0]  mask_a_reg;
  logic [7:0]  mask_b_reg;
  logic [7:0]  ctrl_reg;
  logic [31:0] prdata_reg;
  logic        pslverr_reg;
  logic        irq_reg;

  logic [7:0]  meas_a;
  logic [7:0]  meas_b;
  logic [7:0]  lvl_a;
  logic [7:0]  lvl_b;
  logic [7:0]  hit_a;
  logic [7:0]  hit_b;
  logic [7:0]  clr_a;
  logic [7:0]  clr_b;
  logic [7:0]  rd_value;
  logic        ext_mode;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  logic       setup_ph;
  logic       access_ph;
  logic       aligned;
  logic [5:0] reg_index;
  logic       mapped;
  logic       rd_take_a;
  logic       rd_take_b;
  logic       wr_take;
  logic       soft_reset;

  assign setup_ph   = psel && !penable;
  assign access_ph  = psel && penable;
  assign aligned    = (paddr[1:0] == 2'b00);
  assign reg_index  = paddr[7:2];
  assign mapped     = aligned && (reg_index <= IDX_CTRL);
  assign rd_take_a  = access_ph && !pwrite && aligned &&
                      (reg_index == IDX_FLAGS_A);
  assign rd_take_b  = access_ph && !pwrite && aligned &&
                      (reg_index == IDX_FLAGS_B);
  assign wr_take    = access_ph && pwrite && mapped;
  // The reset bit is a write strobe and never stored.
  assign soft_reset = wr_take && (reg_index == IDX_CTRL) &&
                      pwdata[CTRL_SOFT_RST];
  assign ext_mode   = ctrl_reg[CTRL_EXT_MODE];

  // ----------------------------------------------------------------
  // Limit comparison
  // ----------------------------------------------------------------
  always_comb begin
    meas_a = 8'h00;
    meas_b = 8'h00;
    lvl_a  = 8'h00;
    lvl_b  = 8'h00;
    // The fault line is watched on every cycle in external mode.
    meas_a[BIT_FAULT] = 1'b1;
    lvl_a[BIT_FAULT]  = sensor_fault && ext_mode;
    if (result.valid) begin
      case (result.chan)
        CH_INT_TEMP: begin
          meas_a[BIT_INT_HIGH] = 1'b1;
          meas_a[BIT_INT_LOW]  = 1'b1;
          lvl_a[BIT_INT_HIGH]  = lisr_temp_high(result.value,
                                   limits.int_temp.high);
          lvl_a[BIT_INT_LOW]   = lisr_temp_low(result.value,
                                   limits.int_temp.low);
        end
        CH_EXT_OR_ANALOG_INPUT_ONE: begin
          meas_a[BIT_EXT_HIGH] = 1'b1;
          meas_a[BIT_EXT_LOW]  = 1'b1;
          if (ext_mode) begin
            lvl_a[BIT_EXT_HIGH] = lisr_temp_high(result.value,
                                    limits.ext_temp.high);
            lvl_a[BIT_EXT_LOW]  = lisr_temp_low(result.value,
                                    limits.ext_temp.low);
          end else begin
            // No external reading exists in this mode, so bit 3 stays quiet.
            lvl_a[BIT_EXT_HIGH] = lisr_volt_out(result.value,
                                    limits.analog_input_one);
          end
        end
        CH_AIN_TWO: begin
          meas_a[BIT_AIN_TWO] = 1'b1;
          lvl_a[BIT_AIN_TWO]  = lisr_volt_out(result.value,
                                  limits.analog_input_two);
        end
        CH_AIN_THREE: begin
          meas_a[BIT_AIN_THREE] = 1'b1;
          lvl_a[BIT_AIN_THREE]  = lisr_volt_out(result.value,
                                    limits.analog_input_three);
        end
        CH_AIN_FOUR: begin
          meas_a[BIT_AIN_FOUR] = 1'b1;
          lvl_a[BIT_AIN_FOUR]  = lisr_volt_out(result.value,
                                   limits.analog_input_four);
        end
        CH_SUPPLY: begin
          meas_b[BIT_SUPPLY] = 1'b1;
          lvl_b[BIT_SUPPLY]  = lisr_volt_out(result.value,
                                 limits.supply_voltage);
        end
        default: begin
          meas_a = meas_a;
        end
      endcase
    end
  end

  assign hit_a       = lvl_a & meas_a;
  assign hit_b       = lvl_b & meas_b & FLAGS_B_USED;
  assign cond_a_next = (cond_a_reg & ~meas_a) | hit_a;
  assign cond_b_next = (cond_b_reg & ~meas_b) | hit_b;

  // ----------------------------------------------------------------
  // Flag registers
  // ----------------------------------------------------------------
  // Only bits that the host actually saw in this read may clear; a bit
  // that rose after the read data was latched survives until the next read.
  assign clr_a = rd_take_a ? (prdata_reg[7:0] & ~cond_a_next) : 8'h00;
  assign clr_b = rd_take_b ? (prdata_reg[7:0] & ~cond_b_next) : 8'h00;

  // A new event wins over a read clear; a software reset wins over all.
  assign flags_a_next = soft_reset ? FLAGS_RESET :
                        ((flags_a_reg & ~clr_a) | hit_a);
  assign flags_b_next = soft_reset ? FLAGS_RESET :
                        (((flags_b_reg & ~clr_b) | hit_b) &
                         FLAGS_B_USED);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_a_reg <= FLAGS_RESET;
      flags_b_reg <= FLAGS_RESET;
    end else begin
      flags_a_reg <= flags_a_next;
      flags_b_reg <= flags_b_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cond_a_reg <= 8'h00;
      cond_b_reg <= 8'h00;
    end else begin
      cond_a_reg <= cond_a_next;
      cond_b_reg <= cond_b_next;
    end
  end

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  // Writes to the flag registers fall through here unmatched.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_a_reg <= MASK_A_RESET;
      mask_b_reg <= MASK_B_RESET;
      ctrl_reg   <= CTRL_RESET;
    end else if (wr_take) begin
      case (reg_index)
        IDX_MASK_A: begin
          mask_a_reg <= pwdata[7:0];
        end
        IDX_MASK_B: begin
          mask_b_reg <= pwdata[7:0] & FLAGS_B_USED;
        end
        IDX_CTRL: begin
          ctrl_reg[CTRL_EXT_MODE] <= pwdata[CTRL_EXT_MODE];
        end
        default: begin
          ctrl_reg <= ctrl_reg;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  always_comb begin
    rd_value = 8'h00;
    case (reg_index)
      IDX_FLAGS_A: rd_value = flags_a_reg;
      IDX_FLAGS_B: rd_value = flags_b_reg & FLAGS_B_USED;
      IDX_MASK_A:  rd_value = mask_a_reg;
      IDX_MASK_B:  rd_value = mask_b_reg;
      IDX_CTRL:    rd_value = ctrl_reg & 8'h01;
      default:     rd_value = 8'h00;
    endcase
    if (!aligned) begin
      rd_value = 8'h00;
    end
  end

  // Data and error are latched in the setup phase so that the access
  // phase can finish at once with registered outputs.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else if (setup_ph) begin
      prdata_reg  <= {24'h00_0000, rd_value};
      pslverr_reg <= !mapped;
    end
  end

  assign prdata  = prdata_reg;
  assign pslverr = pslverr_reg;
  assign pready  = 1'b1;

  // ----------------------------------------------------------------
  // Interrupt output
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(flags_a_next & mask_a_reg) |
                 |(flags_b_next & mask_b_reg);
    end
  end

  assign irq = irq_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_read_keeps_live: assert property (
    @(posedge pclk) disable iff (!presetn)
    (rd_take_a && !soft_reset) |=>
      ((flags_a_reg & $past(prdata_reg[7:0] & cond_a_next)) ==
       $past(prdata_reg[7:0] & cond_a_next)))
    else $error("flag with live condition cleared by read");

  a_read_clears_gone: assert property (
    @(posedge pclk) disable iff (!presetn)
    (rd_take_a && (hit_a == 8'h00)) |=>
      ((flags_a_reg & $past(prdata_reg[7:0] & ~cond_a_next)) == 8'h00))
    else $error("corrected flag not cleared by read");

  a_soft_reset_all: assert property (
    @(posedge pclk) disable iff (!presetn)
    soft_reset |=> (flags_a_reg == 8'h00) && (flags_b_reg == 8'h00))
    else $error("software reset left a flag set");

  a_int_high_set: assert property (
    @(posedge pclk) disable iff (!presetn)
    (result.valid && result.chan == CH_INT_TEMP && !soft_reset &&
     ($signed(result.value) > $signed(limits.int_temp.high)))
      |=> flags_a_reg[BIT_INT_HIGH])
    else $error("internal high event not flagged");

  a_int_low_set: assert property (
    @(posedge pclk) disable iff (!presetn)
    (result.valid && result.chan == CH_INT_TEMP && !soft_reset &&
     ($signed(result.value) <= $signed(limits.int_temp.low)))
      |=> flags_a_reg[BIT_INT_LOW])
    else $error("internal low event not flagged");

  a_ext_high_set: assert property (
    @(posedge pclk) disable iff (!presetn)
    (result.valid && result.chan == CH_EXT_OR_ANALOG_INPUT_ONE && ext_mode &&
     !soft_reset &&
     ($signed(result.value) > $signed(limits.ext_temp.high)))
      |=> flags_a_reg[BIT_EXT_HIGH])
    else $error("external high event not flagged");

  a_ain_one_set: assert property (
    @(posedge pclk) disable iff (!presetn)
    (result.valid && result.chan == CH_EXT_OR_ANALOG_INPUT_ONE && !ext_mode &&
     !soft_reset &&
     ((result.value > limits.analog_input_one.high) ||
      (result.value <= limits.analog_input_one.low)))
      |=> flags_a_reg[BIT_EXT_HIGH])
    else $error("analog input one event not flagged");

  a_ext_low_set: assert property (
    @(posedge pclk) disable iff (!presetn)
    (result.valid && result.chan == CH_EXT_OR_ANALOG_INPUT_ONE && ext_mode &&
     !soft_reset &&
     ($signed(result.value) <= $signed(limits.ext_temp.low)))
      |=> flags_a_reg[BIT_EXT_LOW])
    else $error("external low event not flagged");

  a_fault_set: assert property (
    @(posedge pclk) disable iff (!presetn)
    (sensor_fault && ext_mode && !soft_reset)
      |=> flags_a_reg[BIT_FAULT])
    else $error("sensor fault not flagged");

  a_ain_two_set: assert property (
    @(posedge pclk) disable iff (!presetn)
    (result.valid && result.chan == CH_AIN_TWO && !soft_reset &&
     ((result.value > limits.analog_input_two.high) ||
      (result.value <= limits.analog_input_two.low)))
      |=> flags_a_reg[BIT_AIN_TWO])
    else $error("analog input two event not flagged");

  a_ain_three_set: assert property (
    @(posedge pclk) disable iff (!presetn)
    (result.valid && result.chan == CH_AIN_THREE && !soft_reset &&
     ((result.value > limits.analog_input_three.high) ||
      (result.value <= limits.analog_input_three.low)))
      |=> flags_a_reg[BIT_AIN_THREE])
    else $error("analog input three event not flagged");

  a_ain_four_set: assert property (
    @(posedge pclk) disable iff (!presetn)
    (result.valid && result.chan == CH_AIN_FOUR && !soft_reset &&
     ((result.value > limits.analog_input_four.high) ||
      (result.value <= limits.analog_input_four.low)))
      |=> flags_a_reg[BIT_AIN_FOUR])
    else $error("analog input four event not flagged");

  a_supply_set: assert property (
    @(posedge pclk) disable iff (!presetn)
    (result.valid && result.chan == CH_SUPPLY && !soft_reset &&
     ((result.value > limits.supply_voltage.high) ||
      (result.value <= limits.supply_voltage.low)))
      |=> flags_b_reg[BIT_SUPPLY])
    else $error("supply event not flagged");

  a_irq_follows: assert property (
    @(posedge pclk) disable iff (!presetn)
    ((flags_a_reg & mask_a_reg) != 8'h00) ##1
      ((flags_a_reg & mask_a_reg) != 8'h00) |-> irq)
    else $error("unmasked flag does not drive irq");

  a_unused_zero: assert property (
    @(posedge pclk) disable iff (!presetn)
    (setup_ph && !pwrite && aligned && reg_index == IDX_FLAGS_B)
      |=> (prdata_reg[31:0] & ~{24'h00_0000, FLAGS_B_USED}) == 32'h0)
    else $error("unused flag bits read nonzero");

endmodule

`default_nettype wire

/* sim/lisr_host.sv */
// APB host model that issues register transfers to the status block.
`default_nettype none

module lisr_host (
  input  wire logic        pclk,
  output var  logic        psel,
  output var  logic        penable,
  output var  logic        pwrite,
  output var  logic [7:0]  paddr,
  output var  logic [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
  end

  // Released address and data are inverted so a stale value never matches.
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] rd,
                      output logic err);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Only the bench watchdog ends a wait for the answer.
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    paddr   <= ~a;
    pwdata  <= ~d;
  endtask
endmodule

`default_nettype wire

/* sim/limit_interrupt_status_bench.sv */
// Self-checking bench for the limit interrupt status block.
`default_nettype none

module limit_interrupt_status_bench;
  import lisr_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic         pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic         sensor_fault, irq;
  logic [7:0]   paddr;
  logic [31:0]  pwdata, prdata;
  lisr_result_t result;
  lisr_limits_t lim;
  int           failures, cmp_count, seed;
  logic [7:0]   fa, ca, ma;
  logic         fb, cb, mb, extm;
  lisr_window_t w;
  logic [9:0]   v;

  lisr_host host (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

  lisr_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .result(result),
    .limits(lim), .sensor_fault(sensor_fault), .irq(irq));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // ----------------------------------------------------------------
  // Reference model
  // ----------------------------------------------------------------
  function automatic int sx(input logic [9:0] x);
    return x[9] ? int'(x) - 1024 : int'(x);
  endfunction

  function automatic logic vo(input logic [9:0] x, input lisr_window_t u);
    return (int'(x) > int'(u.high)) || (int'(x) <= int'(u.low));
  endfunction

  function automatic lisr_window_t win(input int k);
    return lim[139 - 20 * k -: 20];
  endfunction

  function automatic int kidx(input int ch);
    if (ch == 1) return extm ? 1 : 2;
    return (ch == 0) ? 0 : (ch == 5) ? 6 : ch + 1;
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Stimulus tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    host.xfer(1'b1, a, d, r, e);
    chk("write error", {31'h0, e}, 32'h0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                    input logic err);
    logic [31:0] r;
    logic        e;
    host.xfer(1'b0, a, 32'h0, r, e);
    chk("read data", r, exp);
    chk("slave error", {31'h0, e}, {31'h0, err});
  endtask

  // A read clears only flags whose condition has gone away.
  task automatic rd_flags();
    rd(8'h00, {24'h0, fa}, 1'b0);
    fa = fa & ca;
    rd(8'h04, {27'h0, fb, 4'h0}, 1'b0);
    fb = fb & cb;
  endtask

  task automatic chk_irq();
    repeat (2) @(posedge pclk);
    @(negedge pclk);
    chk("irq", {31'h0, irq}, {31'h0, |(fa & ma) | (fb & mb)});
  endtask

  task automatic ctrl(input logic [31:0] d);
    wr(8'h10, d);
    extm = d[0];
    if (d[1]) begin
      fa = 8'h00;
      fb = 1'b0;
    end
    rd(8'h10, {31'h0, extm}, 1'b0);
  endtask

  task automatic send(input int ch, input logic [9:0] x);
    @(posedge pclk);
    result <= '{1'b1, lisr_chan_t'(ch[2:0]), x};
    @(posedge pclk);
    result.valid <= 1'b0;
    case (ch)
      0: begin
        ca[0] = sx(x) > sx(lim.int_temp.high);
        ca[1] = sx(x) <= sx(lim.int_temp.low);
        fa[1:0] = fa[1:0] | ca[1:0];
      end
      1: begin
        ca[2] = extm ? sx(x) > sx(lim.ext_temp.high)
                     : vo(x, win(2));
        ca[3] = extm && sx(x) <= sx(lim.ext_temp.low);
        fa[3:2] = fa[3:2] | ca[3:2];
      end
      5: begin
        cb = vo(x, win(6));
        fb = fb | cb;
      end
      default: begin
        ca[ch + 3] = vo(x, win(ch + 1));
        fa[ch + 3] = fa[ch + 3] | ca[ch + 3];
      end
    endcase
  endtask

  task automatic fault(input logic lvl);
    @(posedge pclk);
    sensor_fault <= lvl;
    @(posedge pclk);
    ca[4] = lvl;
    if (lvl && extm) fa[4] = 1'b1;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    seed = 12346;
    failures = 0;
    cmp_count = 0;
    presetn = 1'b0;
    result = '0;
    sensor_fault = 1'b0;
    lim = {10'h064, 10'h3F6, 10'h3FC, 10'h000, 10'h300, 10'h100,
           10'h280, 10'h080, 10'h200, 10'h040, 10'h3F0, 10'h010,
           10'h2C0, 10'h1C0};
    fa = 8'h00;
    ca = 8'h00;
    fb = 1'b0;
    cb = 1'b0;
    ma = 8'hFF;
    mb = 1'b1;
    extm = 1'b1;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd_flags();
    chk_irq();
    wr(8'h00, 32'hFF);
    wr(8'h04, 32'hFF);
    rd_flags();
    rd(8'h40, 32'h0, 1'b1);
    rd(8'h10, 32'h1, 1'b0);
    // Limits and their neighbours, first external then analog mode.
    for (int p = 0; p < 2; p++) begin
      for (int ch = 0; ch < 6; ch++) begin
        for (int j = 0; j < 4; j++) begin
          w = win(kidx(ch));
          v = (j[1] ? w.low : w.high) + 10'(j[0]);
          send(ch, v);
          rd_flags();
          chk_irq();
        end
      end
      fault(1'b1);
      rd_flags();
      rd_flags();
      fault(1'b0);
      rd_flags();
      chk_irq();
      ctrl(32'h0);
    end
    for (int i = 0; i < 200; i++) begin
      if (i == 100) ctrl(32'h1);
      send(($random(seed) & 32'h7FFFFFFF) % 6, 10'($random(seed)));
      if (i % 4 == 3) begin
        rd_flags();
        chk_irq();
      end
    end
    send(0, 10'h1FF);
    send(5, 10'h3FF);
    ctrl(32'h3);
    rd_flags();
    wr(8'h08, 32'h0);
    wr(8'h0C, 32'h0);
    ma = 8'h00;
    mb = 1'b0;
    send(5, 10'h3FF);
    send(0, 10'h1FF);
    chk_irq();
    wr(8'h08, 32'hFF);
    wr(8'h0C, 32'h10);
    ma = 8'hFF;
    mb = 1'b1;
    chk_irq();
    send(0, 10'h000);
    rd_flags();
    rd_flags();
    chk_irq();
    finish_test();
  end

  // The whole sequence needs about 1500 cycles; this is far beyond.
  initial begin
    #200000;
    failures++;
    finish_test();
  end
endmodule

`default_nettype wire
